/* File: hw/psp_consts.vh */
// constants of the packed-simd pack and tag control block
// assumes inclusion by bare name from the design files under hw/
`ifndef PSP_CONSTS_VH
`define PSP_CONSTS_VH

// instruction classes on instr_op_i
`define PSP_OP_W           4
`define PSP_OP_NOP         4'h0
`define PSP_OP_PK_SSWB     4'h1
`define PSP_OP_PK_SSDW     4'h2
`define PSP_OP_PK_USWB     4'h3
`define PSP_OP_SIMD_OTHER  4'h4
`define PSP_OP_EMPTY       4'h5
`define PSP_OP_IDENTIFY    4'h6
`define PSP_OP_FP_ARITH    4'h7
`define PSP_OP_FP_SAVE     4'h8
`define PSP_OP_FP_RESTORE  4'h9

// tag word
`define PSP_TAG_W          16
`define PSP_TAG_ALL_VALID  16'h0000
`define PSP_TAG_ALL_EMPTY  16'hffff

// identify instruction
`define PSP_LEAF_FEATURES  32'h00000001
`define PSP_FEAT_SIMD_BIT  23

// not-a-number pushed on a soft fault: sign, exponent, significand
`define PSP_NAN_SIGN       1'b0
`define PSP_NAN_EXP        15'h7fff
`define PSP_NAN_MANT       64'hc000000000000000

// result layout
`define PSP_RES_W          80
`define PSP_RES_PAD        16'h0000

// segment selects
`define PSP_SEG_W          3
`define PSP_SEG_DEFAULT    3'h3

// register byte addresses
`define PSP_ADDR_W         5
`define PSP_REG_CTRL       5'h00
`define PSP_REG_STATUS     5'h04
`define PSP_REG_MASK       5'h08
`define PSP_REG_TAG        5'h0c
`define PSP_REG_FEATURE    5'h10

// control bits
`define PSP_CTRL_EMU       0
`define PSP_CTRL_FPMASK    1
`define PSP_CTRL_W         2

// status and mask bits
`define PSP_EV_W           3
`define PSP_EV_INVOP       0
`define PSP_EV_FPEXC       1
`define PSP_EV_SOFTNAN     2

// tag register: dirty flag position
`define PSP_TAGREG_DIRTY   16

`endif

/* File: hw/psp_sat_lane.v */
// one saturating narrowing lane: signed input to signed or unsigned output
// assumes a purely combinational use inside the pack datapath
`timescale 1ns/1ns
module psp_sat_lane #(
	parameter IN_W  = 16,
	parameter OUT_W = 8
) (
	input  wire [IN_W-1:0]  val_i,
	input  wire             uns_i,
	output reg  [OUT_W-1:0] sat_o
);

	wire sign_w;
	wire fits_s_w;
	wire fits_u_w;

	assign sign_w   = val_i[IN_W-1];
	// signed fits when the output sign bit and all bits above it agree
	assign fits_s_w = (&val_i[IN_W-1:OUT_W-1]) | ~(|val_i[IN_W-1:OUT_W-1]);
	assign fits_u_w = ~(|val_i[IN_W-1:OUT_W]);

	always @*
	begin
		if (uns_i)
		begin
			if (sign_w)
				sat_o = {OUT_W{1'b0}};
			else if (!fits_u_w)
				sat_o = {OUT_W{1'b1}};
			else
				sat_o = val_i[OUT_W-1:0];
		end
		else
		begin
			if (fits_s_w)
				sat_o = val_i[OUT_W-1:0];
			else if (sign_w)
				sat_o = {1'b1, {(OUT_W-1){1'b0}}};
			else
				sat_o = {1'b0, {(OUT_W-1){1'b1}}};
		end
	end

endmodule

/* File: hw/psp_core.v */
// packed-simd pack datapath, tag word control, prefix decode, identify report
// assumes a core-side issue port that is always accepted while ce_i is high
// and an avalon-mm master for the control and status registers
//
// Overview of operation
// - signed pack clamps to narrower signed range
// - unsigned pack clamps words to byte range
// - saturate to nearest limit, never wrap
// - simd state aliases float state, no mode
// - float save/restore also carries simd state
// - every simd instruction except state-empty sets tags valid
// - state-empty instruction sets all tags empty
// - address-size, segment prefixes affect memory operands
// - those prefixes ignored without memory operand
// - lock prefix gives invalid opcode
// - identify reports simd support in bit 23
// - support bit stays set under emulation flag
// - emulation flag makes simd instructions invalid
// - float op on valid tags may fault
// - masked fault pushes all-ones-exponent nan
`timescale 1ns/1ns
`include "psp_consts.vh"
module psp_core #(
	parameter SIMD_IMPL = 1'b1
) (
	input  wire                    clk_i,
	input  wire                    nrst_i,
	input  wire                    ce_i,
	// instruction issue
	input  wire                    instr_valid_i,
	output wire                    instr_ready_o,
	input  wire [`PSP_OP_W-1:0]    instr_op_i,
	input  wire                    pfx_lock_i,
	input  wire                    pfx_addr_size_i,
	input  wire                    pfx_seg_i,
	input  wire [`PSP_SEG_W-1:0]   pfx_seg_sel_i,
	input  wire                    pfx_opsize_i,
	input  wire                    pfx_rep_i,
	input  wire                    has_mem_i,
	input  wire                    code32_i,
	input  wire [63:0]             dst_i,
	input  wire [63:0]             src_i,
	input  wire [31:0]             identify_leaf_register_i,
	// results
	output reg                     result_valid_o,
	output reg  [`PSP_RES_W-1:0]   result_o,
	output reg                     mem_valid_o,
	output reg                     mem_addr32_o,
	output reg  [`PSP_SEG_W-1:0]   mem_seg_o,
	output reg                     invalid_opcode_o,
	output reg                     fp_exception_o,
	output reg                     nan_push_o,
	output reg  [`PSP_TAG_W-1:0]   tag_word_o,
	// avalon-mm slave
	input  wire [`PSP_ADDR_W-1:0]  avs_address,
	input  wire                    avs_read,
	input  wire                    avs_write,
	input  wire [31:0]             avs_writedata,
	output reg  [31:0]             avs_readdata,
	output wire                    avs_waitrequest,
	output wire                    irq_o
);

////////////////////////////////////////////////////////////////////////////////
// state

	reg  [`PSP_CTRL_W-1:0]   ctrl_r;
	reg  [`PSP_EV_W-1:0]     status_r;
	reg  [`PSP_EV_W-1:0]     mask_r;
	reg                      dirty_r;
	reg  [31:0]              feature_r;
	reg                      ack_r;

	wire                     emu_w;
	wire                     fpmask_w;
	wire                     go_w;
	wire                     is_pack_w;
	wire                     is_simd_w;
	wire                     invop_w;
	wire                     fp_stale_w;
	wire [31:0]              feature_w;
	wire [63:0]              pack_bytes_w;
	wire [63:0]              pack_words_w;
	wire [`PSP_EV_W-1:0]     ev_w;
	wire                     bus_req_w;
	wire                     wr_go_w;
	wire                     is_sswb_w;
	wire                     is_ssdw_w;
	wire                     is_uswb_w;
	wire                     is_other_w;
	wire                     is_empty_w;
	wire                     is_fparith_w;
	wire                     fault_w;
	wire                     soft_w;

	reg                      result_valid_nxt;
	reg  [`PSP_RES_W-1:0]    result_nxt;
	reg                      mem_valid_nxt;
	reg                      mem_addr32_nxt;
	reg  [`PSP_SEG_W-1:0]    mem_seg_nxt;
	reg  [`PSP_TAG_W-1:0]    tag_nxt;
	reg                      dirty_nxt;
	reg  [31:0]              feature_nxt;
	reg  [31:0]              rdata_nxt;
	reg  [`PSP_EV_W-1:0]     status_nxt;

	assign emu_w    = ctrl_r[`PSP_CTRL_EMU];
	assign fpmask_w = ctrl_r[`PSP_CTRL_FPMASK];
	assign go_w     = ce_i & instr_valid_i;
	assign instr_ready_o = ce_i;

////////////////////////////////////////////////////////////////////////////////
// decode

	assign is_sswb_w    = (instr_op_i == `PSP_OP_PK_SSWB);
	assign is_ssdw_w    = (instr_op_i == `PSP_OP_PK_SSDW);
	assign is_uswb_w    = (instr_op_i == `PSP_OP_PK_USWB);
	assign is_other_w   = (instr_op_i == `PSP_OP_SIMD_OTHER);
	assign is_empty_w   = (instr_op_i == `PSP_OP_EMPTY);
	assign is_fparith_w = (instr_op_i == `PSP_OP_FP_ARITH);

	assign is_pack_w = is_sswb_w | is_ssdw_w | is_uswb_w;
	assign is_simd_w = is_pack_w | is_other_w | is_empty_w;

	// operand-size and repeat prefixes are deliberately not looked at
	assign invop_w   = is_simd_w & (pfx_lock_i | emu_w);

	// valid tags left by simd use meet a float instruction
	assign fp_stale_w = is_fparith_w & dirty_r;
	assign fault_w    = go_w & fp_stale_w & ~fpmask_w;
	assign soft_w     = go_w & fp_stale_w & fpmask_w;

	// support bit does not depend on the emulation flag
	assign feature_w = (identify_leaf_register_i == `PSP_LEAF_FEATURES) ?
	                   ({31'h00000000, SIMD_IMPL} << `PSP_FEAT_SIMD_BIT) :
	                   32'h00000000;

////////////////////////////////////////////////////////////////////////////////
// pack datapath

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1)
		begin : g_byte
			wire [15:0] wsel_w;
			// lanes 0..3 from destination words, 4..7 from source words
			assign wsel_w = (gi < 4) ? dst_i[16*(gi%4) +: 16]
			                         : src_i[16*(gi%4) +: 16];
			psp_sat_lane #(
				.IN_W  (16),
				.OUT_W (8)
			) u_lane (
				.val_i (wsel_w),
				.uns_i (is_uswb_w),
				.sat_o (pack_bytes_w[8*gi +: 8])
			);
		end
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_word
			wire [31:0] dsel_w;
			assign dsel_w = (gi < 2) ? dst_i[32*(gi%2) +: 32]
			                         : src_i[32*(gi%2) +: 32];
			psp_sat_lane #(
				.IN_W  (32),
				.OUT_W (16)
			) u_lane (
				.val_i (dsel_w),
				.uns_i (1'b0),
				.sat_o (pack_words_w[16*gi +: 16])
			);
		end
	endgenerate

////////////////////////////////////////////////////////////////////////////////
// execute: next values

	always @*
	begin
		result_valid_nxt = go_w & ~invop_w & ~fault_w;
		mem_valid_nxt    = go_w & is_simd_w & ~invop_w & has_mem_i;
		mem_addr32_nxt   = mem_addr32_o;
		mem_seg_nxt      = mem_seg_o;
		result_nxt       = result_o;
		feature_nxt      = feature_r;
		tag_nxt          = tag_word_o;
		dirty_nxt        = dirty_r;
		if (go_w)
		begin
			// prefixes only steer the address of a memory operand
			mem_addr32_nxt = (has_mem_i & pfx_addr_size_i) ? ~code32_i
			                                                : code32_i;
			mem_seg_nxt    = (has_mem_i & pfx_seg_i) ? pfx_seg_sel_i
			                                          : `PSP_SEG_DEFAULT;
			case (instr_op_i)
				`PSP_OP_PK_SSWB,
				`PSP_OP_PK_USWB:
					if (!invop_w)
						result_nxt = {`PSP_RES_PAD, pack_bytes_w};
				`PSP_OP_PK_SSDW:
					if (!invop_w)
						result_nxt = {`PSP_RES_PAD, pack_words_w};
				`PSP_OP_IDENTIFY:
				begin
					result_nxt  = {48'h000000000000, feature_w};
					feature_nxt = feature_w;
				end
				`PSP_OP_FP_ARITH:
					if (soft_w)
						result_nxt = {`PSP_NAN_SIGN, `PSP_NAN_EXP,
						              `PSP_NAN_MANT};
				`PSP_OP_FP_SAVE:
					result_nxt = {64'h0000000000000000, tag_word_o};
				`PSP_OP_FP_RESTORE:
				begin
					tag_nxt   = src_i[`PSP_TAG_W-1:0];
					dirty_nxt = (src_i[`PSP_TAG_W-1:0] != `PSP_TAG_ALL_EMPTY);
				end
				default:
					result_nxt = result_o;
			endcase
			// simd instructions write the same tag word the float unit uses
			if (is_simd_w & ~invop_w)
			begin
				if (is_empty_w)
				begin
					tag_nxt   = `PSP_TAG_ALL_EMPTY;
					dirty_nxt = 1'b0;
				end
				else
				begin
					tag_nxt   = `PSP_TAG_ALL_VALID;
					dirty_nxt = 1'b1;
				end
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
// execute: registers

	always @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			result_valid_o   <= 1'b0;
			result_o         <= {`PSP_RES_W{1'b0}};
			mem_valid_o      <= 1'b0;
			mem_addr32_o     <= 1'b0;
			mem_seg_o        <= `PSP_SEG_DEFAULT;
			invalid_opcode_o <= 1'b0;
			fp_exception_o   <= 1'b0;
			nan_push_o       <= 1'b0;
			tag_word_o       <= `PSP_TAG_ALL_EMPTY;
			dirty_r          <= 1'b0;
			feature_r        <= 32'h00000000;
		end
		else if (ce_i)
		begin
			result_valid_o   <= result_valid_nxt;
			invalid_opcode_o <= go_w & invop_w;
			fp_exception_o   <= fault_w;
			nan_push_o       <= soft_w;
			mem_valid_o      <= mem_valid_nxt;
			mem_addr32_o     <= mem_addr32_nxt;
			mem_seg_o        <= mem_seg_nxt;
			result_o         <= result_nxt;
			tag_word_o       <= tag_nxt;
			dirty_r          <= dirty_nxt;
			feature_r        <= feature_nxt;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// events and interrupt

	assign ev_w  = {nan_push_o, fp_exception_o, invalid_opcode_o};
	assign irq_o = |(status_r & mask_r);

////////////////////////////////////////////////////////////////////////////////
// avalon-mm slave: one wait cycle, then read data stand with waitrequest low

	assign bus_req_w       = avs_read | avs_write;
	// a low clock enable keeps the master waiting, so no access is lost
	assign avs_waitrequest = bus_req_w & ~(ack_r & ce_i);
	assign wr_go_w         = ce_i & avs_write & ack_r;

////////////////////////////////////////////////////////////////////////////////
// register read mux and status next value

	always @*
	begin
		case (avs_address)
			`PSP_REG_CTRL:
				rdata_nxt = {30'h00000000, ctrl_r};
			`PSP_REG_STATUS:
				rdata_nxt = {29'h00000000, status_r};
			`PSP_REG_MASK:
				rdata_nxt = {29'h00000000, mask_r};
			`PSP_REG_TAG:
				rdata_nxt = {15'h0000, dirty_r, tag_word_o};
			`PSP_REG_FEATURE:
				rdata_nxt = feature_r;
			default:
				rdata_nxt = 32'h00000000;
		endcase
	end

	// new events win over a write-one clear in the same cycle
	always @*
	begin
		status_nxt = status_r | ev_w;
		if (wr_go_w && avs_address == `PSP_REG_STATUS)
			status_nxt = (status_r & ~avs_writedata[`PSP_EV_W-1:0]) | ev_w;
	end

	always @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			ack_r        <= 1'b0;
			avs_readdata <= 32'h00000000;
			ctrl_r       <= {`PSP_CTRL_W{1'b0}};
			mask_r       <= {`PSP_EV_W{1'b0}};
			status_r     <= {`PSP_EV_W{1'b0}};
		end
		else if (ce_i)
		begin
			ack_r    <= bus_req_w & ~ack_r;
			status_r <= status_nxt;
			if (avs_read & ~ack_r)
				avs_readdata <= rdata_nxt;
			if (wr_go_w && avs_address == `PSP_REG_CTRL)
				ctrl_r <= avs_writedata[`PSP_CTRL_W-1:0];
			if (wr_go_w && avs_address == `PSP_REG_MASK)
				mask_r <= avs_writedata[`PSP_EV_W-1:0];
		end
	end

endmodule

/* File: tb/psp_core_assertions.sv */
// assertions on the issue port, tag word and prefix outputs of psp_core
// assumes the consts header on the include path; bound below by name
`timescale 1ns/1ns
`include "psp_consts.vh"
module psp_core_chk (
	input wire                 clk_i,
	input wire                 nrst_i,
	input wire                 ce_i,
	input wire                 instr_valid_i,
	input wire [`PSP_OP_W-1:0] instr_op_i,
	input wire                 pfx_lock_i,
	input wire                 pfx_addr_size_i,
	input wire                 has_mem_i,
	input wire                 code32_i,
	input wire                 result_valid_o,
	input wire [79:0]          result_o,
	input wire                 mem_valid_o,
	input wire                 mem_addr32_o,
	input wire [2:0]           mem_seg_o,
	input wire                 invalid_opcode_o,
	input wire                 fp_exception_o,
	input wire                 nan_push_o,
	input wire [15:0]          tag_word_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (!nrst_i);
wire take = ce_i && instr_valid_i;
wire emp  = take && instr_op_i == `PSP_OP_EMPTY;
wire simd = take && instr_op_i >= `PSP_OP_PK_SSWB && instr_op_i <= `PSP_OP_SIMD_OTHER;
////////////////////////////////////////////////////////////////
AST_TAG_VALID: assert property (
	simd && !pfx_lock_i |=> tag_word_o == 16'h0000 || invalid_opcode_o)
	else $error("tag word not valid after simd op");
AST_TAG_EMPTY: assert property (
	emp && !pfx_lock_i |=> tag_word_o == 16'hffff || invalid_opcode_o)
	else $error("tag word not empty after empty op");
AST_LOCK: assert property (
	(simd || emp) && pfx_lock_i |=> invalid_opcode_o && !result_valid_o)
	else $error("locked simd op not refused");
AST_INV_TAG: assert property (
	invalid_opcode_o |-> $stable(tag_word_o))
	else $error("refused op changed tag word");
AST_ADDR_MEM: assert property (
	simd && has_mem_i && pfx_addr_size_i
	|=> invalid_opcode_o || mem_valid_o && mem_addr32_o != $past(code32_i))
	else $error("address prefix not applied");
AST_ADDR_NOMEM: assert property (
	simd && !has_mem_i |=> invalid_opcode_o || !mem_valid_o
	&& mem_addr32_o == $past(code32_i) && mem_seg_o == `PSP_SEG_DEFAULT)
	else $error("prefix applied without memory operand");
AST_FAULT_CAUSE: assert property (
	fp_exception_o || nan_push_o |-> $past(instr_valid_i)
	&& $past(instr_op_i) == `PSP_OP_FP_ARITH && $past(tag_word_o) != 16'hffff)
	else $error("float fault without stale tags");
AST_NAN: assert property (
	nan_push_o |-> result_valid_o && !fp_exception_o && result_o[78:64] == 15'h7fff)
	else $error("soft fault result wrong");
endmodule
bind psp_core psp_core_chk u_chk (.clk_i, .nrst_i, .ce_i, .instr_valid_i, .instr_op_i,
	.pfx_lock_i, .pfx_addr_size_i, .has_mem_i, .code32_i, .result_valid_o, .result_o,
	.mem_valid_o, .mem_addr32_o, .mem_seg_o, .invalid_opcode_o, .fp_exception_o,
	.nan_push_o, .tag_word_o);

/* File: tb/tb.sv */
// self-checking bench for psp_core
// assumes the consts header on the include path and the checker bound in
`timescale 1ns/1ns
`include "psp_consts.vh"
module tb;
reg         clk_i = 0, nrst_i = 0, ce_i = 1, instr_valid_i = 0, avs_read = 0, avs_write = 0;
reg  [3:0]  instr_op_i = 0;
reg         pfx_lock_i = 0, pfx_addr_size_i = 0, pfx_seg_i = 0, has_mem_i = 0, irq_a;
reg  [63:0] dst_i = 0, src_i = 0;
reg  [31:0] leaf_r = 0, avs_writedata = 0, q;
reg  [4:0]  avs_address = 0;
wire [79:0] result_o;
wire [15:0] tag_word_o;
wire [2:0]  mem_seg_o;
wire [31:0] avs_readdata;
wire        result_valid_o, mem_valid_o, mem_addr32_o, invalid_opcode_o, instr_ready_o;
wire        fp_exception_o, nan_push_o, avs_waitrequest, irq_o;
int         n_fail = 0, checks = 0;
always #20 clk_i = ~clk_i;
psp_core dut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .instr_valid_i(instr_valid_i),
	.instr_ready_o(instr_ready_o), .instr_op_i(instr_op_i), .pfx_lock_i(pfx_lock_i),
	.pfx_addr_size_i(pfx_addr_size_i), .pfx_seg_i(pfx_seg_i), .pfx_seg_sel_i(3'h5),
	.pfx_opsize_i(pfx_addr_size_i), .pfx_rep_i(pfx_seg_i), .has_mem_i(has_mem_i),
	.code32_i(1'b1), .dst_i(dst_i), .src_i(src_i), .identify_leaf_register_i(leaf_r),
	.result_valid_o(result_valid_o), .result_o(result_o), .mem_valid_o(mem_valid_o),
	.mem_addr32_o(mem_addr32_o), .mem_seg_o(mem_seg_o), .invalid_opcode_o(invalid_opcode_o),
	.fp_exception_o(fp_exception_o), .nan_push_o(nan_push_o), .tag_word_o(tag_word_o),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .irq_o(irq_o));
////////////////////////////////////////////////////////////////
task chk(input string nm, input logic [79:0] s, e);
	checks++;
	if (s !== e)
	begin
		n_fail++;
		$display("[ERR] %s exp %h got %h", nm, e, s);
	end
endtask
task results;
	$display("checks %0d n_fail %0d", checks, n_fail);
	if (n_fail == 0 && checks > 0)
		$display("[ PASS ]");
	else
		$display("[ FAIL ]");
	$finish;
endtask
task iss(input [3:0] op, input [3:0] pf, input [63:0] d, s);
	@(posedge clk_i);
	instr_valid_i <= 1;
	instr_op_i <= op;
	{pfx_lock_i, pfx_addr_size_i, pfx_seg_i, has_mem_i} <= pf;
	dst_i <= d;
	src_i <= s;
	leaf_r <= s[31:0];
	@(posedge clk_i);
	instr_valid_i <= 0;
	@(negedge clk_i);
endtask
task bus(input w, input [4:0] a, input [31:0] d);
	@(posedge clk_i);
	avs_address <= a;
	avs_writedata <= d;
	avs_write <= w;
	avs_read <= !w;
	do @(posedge clk_i); while (avs_waitrequest);
	q = avs_readdata;
	avs_write <= 0;
	avs_read <= 0;
endtask
////////////////////////////////////////////////////////////////
task t_pack;
	iss(`PSP_OP_PK_SSWB, 0, 64'h8000_0080_ff7f_0010, 64'h007f_ff80_0000_7fff);
	chk("sswb", result_o, 80'h7f80007f_807f8010);
	chk("tag", tag_word_o, 0);
	iss(`PSP_OP_PK_USWB, 0, 64'h8000_0080_ff7f_0010, 64'h007f_ff80_0000_7fff);
	chk("uswb", result_o, 80'h7f0000ff_00800010);
	iss(`PSP_OP_PK_SSDW, 0, 64'h8000_0000_0000_8000, 64'hffff_7fff_0000_7fff);
	chk("ssdw", result_o, 80'h8000_7fff_8000_7fff);
	iss(`PSP_OP_EMPTY, 0, 0, 0);
	chk("empty", tag_word_o, 16'hffff);
endtask
task t_lock;
	iss(`PSP_OP_PK_SSWB, 4'h8, 0, 0);
	chk("lock", {invalid_opcode_o, result_valid_o, tag_word_o}, 18'h2ffff);
endtask
task t_pfx;
	iss(`PSP_OP_SIMD_OTHER, 4'h7, 0, 0);
	chk("mem", {mem_valid_o, mem_addr32_o, mem_seg_o}, 5'h15);
	iss(`PSP_OP_SIMD_OTHER, 4'h6, 0, 0);
	chk("nomem", {mem_valid_o, mem_addr32_o, mem_seg_o}, 5'h0b);
endtask
task t_emu;
	iss(`PSP_OP_EMPTY, 0, 0, 0);
	bus(1, `PSP_REG_CTRL, 1);
	iss(`PSP_OP_PK_SSWB, 0, 0, 0);
	chk("emu", {invalid_opcode_o, tag_word_o}, 17'h1ffff);
	iss(`PSP_OP_IDENTIFY, 0, 0, 1);
	chk("feat", result_o[23], 1);
	bus(0, `PSP_REG_FEATURE, 0);
	chk("featreg", q[23], 1);
	iss(`PSP_OP_IDENTIFY, 0, 0, 2);
	chk("leaf", result_o, 0);
	bus(1, `PSP_REG_CTRL, 0);
endtask
task t_fp;
	iss(`PSP_OP_SIMD_OTHER, 0, 0, 0);
	iss(`PSP_OP_FP_ARITH, 0, 0, 0);
	chk("fpexc", {fp_exception_o, result_valid_o}, 2'b10);
	bus(1, `PSP_REG_CTRL, 2);
	iss(`PSP_OP_FP_ARITH, 0, 0, 0);
	chk("nan", nan_push_o, 1);
	chk("nanval", result_o, {1'b0, 15'h7fff, 64'hc000_0000_0000_0000});
	iss(`PSP_OP_EMPTY, 0, 0, 0);
	iss(`PSP_OP_FP_ARITH, 0, 0, 0);
	chk("nofault", {nan_push_o, fp_exception_o}, 0);
	bus(1, `PSP_REG_CTRL, 0);
endtask
task t_save;
	iss(`PSP_OP_FP_SAVE, 0, 0, 0);
	chk("save", result_o, 80'hffff);
	iss(`PSP_OP_FP_RESTORE, 0, 0, 0);
	chk("rest", tag_word_o, 0);
	iss(`PSP_OP_FP_RESTORE, 0, 0, 64'hffff);
	chk("rest2", tag_word_o, 16'hffff);
endtask
task t_ce;
	iss(`PSP_OP_SIMD_OTHER, 0, 0, 0);
	chk("ready", instr_ready_o, 1);
	@(posedge clk_i);
	ce_i <= 0;
	iss(`PSP_OP_EMPTY, 0, 0, 0);
	chk("frozen", {instr_ready_o, result_valid_o, tag_word_o}, 18'h0);
	@(posedge clk_i);
	ce_i <= 1;
endtask
task t_irq;
	bus(0, `PSP_REG_STATUS, 0);
	chk("status", q[2:0], 3'h7);
	bus(1, `PSP_REG_MASK, 0);
	@(negedge clk_i);
	irq_a = irq_o;
	bus(1, `PSP_REG_MASK, 7);
	@(negedge clk_i);
	chk("irqoff", irq_a, 0);
	chk("irqon", irq_o, 1);
	bus(1, `PSP_REG_STATUS, 7);
	bus(0, `PSP_REG_STATUS, 0);
	chk("w1c", {irq_o, q}, 0);
	bus(0, 5'h1c, 0);
	chk("unmapped", q, 0);
endtask
initial
begin
	repeat (16) @(posedge clk_i);
	nrst_i <= 1;
	t_pack;
	t_lock;
	t_pfx;
	t_emu;
	t_fp;
	t_save;
	t_ce;
	t_irq;
	results;
end
initial
begin
	repeat (3000) @(posedge clk_i);
	n_fail++;
	results;
end
endmodule
